// file: hdl/pdc_regs.sv
/*
 * sampling-pll divider, oscillator bias, lane emphasis, output swing and trigger
 * output configuration bank behind the serial register port.
 * assumes spi pins asynchronous to clk, sclk well below clk/8; ser_ui_tick and
 * ser_reinit come from the serializer on clk.
 */
// Summary of operation
// - first divider code 0,1,2 divides by 5,4,3; code 3 reserved.
// - second divider code 0,1,2 divides by 1,2,4; gives sampling clock.
// - third divider divides sampling clock by literal 1..63; default 32.
// - one emphasis setting drives all eight lanes alike.
// - swing field drives both reference and trigger buffers; 0 is high swing.
// - trigger enable bit 7 switches trigger buffer and divider on or off.
// - trigger select: 16, 32, 64 ui clock or resampled timestamp.
// - serializer-derived trigger clock breaks on serializer re-initialisation.
`timescale 1ns/10ps
`default_nettype none
module pdc_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output var logic spi_sdo,
    output var logic spi_sdo_oe,
    input wire logic ser_ui_tick,
    input wire logic ser_reinit,
    input wire logic timestamp_input,
    output var logic [2:0] first_div_ratio,
    output var logic [2:0] second_div_ratio,
    output var logic [pdc_pkg::THIRD_W-1:0] third_div_ratio,
    output var logic div_code_reserved,
    output var logic [pdc_pkg::BIAS_W-1:0] oscillator_bias_level,
    output var logic [pdc_pkg::LANES*pdc_pkg::EMPH_W-1:0] lane_pre_emphasis,
    output var logic [pdc_pkg::SWING_W-1:0] pll_reference_output_swing,
    output var logic [pdc_pkg::SWING_W-1:0] trigger_output_swing,
    output var logic high_swing_setting,
    output var logic trigger_output_enable,
    output var logic [pdc_pkg::TRIG_SEL_W-1:0] trigger_output_select,
    output var logic trigger_output
);
    logic [pdc_pkg::DATA_W-1:0] fs_r;
    logic [pdc_pkg::DATA_W-1:0] third_r;
    logic [pdc_pkg::DATA_W-1:0] bias_r;
    logic [pdc_pkg::DATA_W-1:0] emph_r;
    logic [pdc_pkg::DATA_W-1:0] swing_r;
    logic [pdc_pkg::DATA_W-1:0] trig_r;
    logic [pdc_pkg::SYNC_W-1:0] filt;
    logic sclk_f;
    logic cs_n_f;
    logic sdi_f;
    logic ts_f;
    logic sclk_prev_r;
    logic rise;
    logic fall;
    pdc_pkg::pdc_spi_state_t state_r;
    logic [4:0] bit_cnt_r;
    logic [pdc_pkg::DATA_W*3-2:0] shift_in_r;
    logic [pdc_pkg::ADDR_W-1:0] addr_r;
    logic rd_r;
    logic [pdc_pkg::DATA_W-1:0] rd_shift_r;
    logic wr_pulse_r;
    logic [pdc_pkg::ADDR_W-1:0] wr_addr_r;
    logic [pdc_pkg::DATA_W-1:0] wr_data_r;
    logic trig_en;
    logic [2:0] trig_sel;
    logic div_clk;

    function automatic logic hit(input logic [pdc_pkg::ADDR_W-1:0] a, input logic [pdc_pkg::ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic [pdc_pkg::HALF_W-1:0] sel_half(input logic [2:0] sel);
        case (sel)
            pdc_pkg::TRIG_SEL_UI16: sel_half = pdc_pkg::HALF_UI16;
            pdc_pkg::TRIG_SEL_UI32: sel_half = pdc_pkg::HALF_UI32;
            pdc_pkg::TRIG_SEL_UI64: sel_half = pdc_pkg::HALF_UI64;
            default: sel_half = pdc_pkg::HALF_NONE;
        endcase
    endfunction : sel_half

    // pin filtering
    pdc_pin_sync #(
        .W(pdc_pkg::SYNC_W),
        .INIT(4'h2)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin_in({timestamp_input, spi_sdi, spi_cs_n, spi_sclk}),
        .level_out(filt)
    );
    assign sclk_f = filt[0];
    assign cs_n_f = filt[1];
    assign sdi_f = filt[2];
    assign ts_f = filt[3];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_f;
        end
    end
    assign rise = sclk_f && !sclk_prev_r && !cs_n_f;
    assign fall = !sclk_f && sclk_prev_r && !cs_n_f;

    // serial frame receive
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= pdc_pkg::PDC_ST_IDLE;
            bit_cnt_r <= 5'h00;
            shift_in_r <= '0;
            addr_r <= '0;
            rd_r <= 1'b0;
        end else if (cs_n_f) begin
            state_r <= pdc_pkg::PDC_ST_IDLE;
            bit_cnt_r <= 5'h00;
        end else if (rise) begin
            shift_in_r <= {shift_in_r[pdc_pkg::DATA_W*3-3:0], sdi_f};
            case (state_r)
                pdc_pkg::PDC_ST_IDLE,
                pdc_pkg::PDC_ST_ADDR: begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    state_r <= pdc_pkg::PDC_ST_ADDR;
                    if (bit_cnt_r == pdc_pkg::CNT_ADDR_DONE) begin
                        addr_r <= {shift_in_r[pdc_pkg::ADDR_W-2:0], sdi_f};
                        rd_r <= (shift_in_r[pdc_pkg::RW_BIT] == pdc_pkg::RW_READ);
                        state_r <= pdc_pkg::PDC_ST_DATA;
                    end
                end
                pdc_pkg::PDC_ST_DATA: begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (bit_cnt_r == pdc_pkg::CNT_FRAME_DONE) begin
                        state_r <= pdc_pkg::PDC_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= pdc_pkg::PDC_ST_IDLE;
                end
            endcase
        end
    end

    // write strobe at the last data bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pulse_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            wr_pulse_r <= rise && !cs_n_f && state_r == pdc_pkg::PDC_ST_DATA &&
                          bit_cnt_r == pdc_pkg::CNT_FRAME_DONE && !rd_r;
            if (rise && state_r == pdc_pkg::PDC_ST_DATA && bit_cnt_r == pdc_pkg::CNT_FRAME_DONE) begin
                wr_addr_r <= addr_r;
                wr_data_r <= {shift_in_r[pdc_pkg::DATA_W-2:0], sdi_f};
            end
        end
    end

    // readback, unmapped addresses read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_shift_r <= '0;
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else if (cs_n_f) begin
            spi_sdo_oe <= 1'b0;
            spi_sdo <= 1'b0;
        end else if (rise && state_r != pdc_pkg::PDC_ST_DATA && bit_cnt_r == pdc_pkg::CNT_ADDR_DONE) begin
            if (hit({shift_in_r[pdc_pkg::ADDR_W-2:0], sdi_f}, pdc_pkg::OFS_FIRST_SECOND)) rd_shift_r <= fs_r;
            else if (hit({shift_in_r[pdc_pkg::ADDR_W-2:0], sdi_f}, pdc_pkg::OFS_THIRD)) rd_shift_r <= third_r;
            else if (hit({shift_in_r[pdc_pkg::ADDR_W-2:0], sdi_f}, pdc_pkg::OFS_BIAS)) rd_shift_r <= bias_r;
            else if (hit({shift_in_r[pdc_pkg::ADDR_W-2:0], sdi_f}, pdc_pkg::OFS_EMPH)) rd_shift_r <= emph_r;
            else if (hit({shift_in_r[pdc_pkg::ADDR_W-2:0], sdi_f}, pdc_pkg::OFS_SWING)) rd_shift_r <= swing_r;
            else if (hit({shift_in_r[pdc_pkg::ADDR_W-2:0], sdi_f}, pdc_pkg::OFS_TRIG)) rd_shift_r <= trig_r;
            else rd_shift_r <= '0;
            spi_sdo_oe <= (shift_in_r[pdc_pkg::RW_BIT] == pdc_pkg::RW_READ);
        end else if (fall && state_r == pdc_pkg::PDC_ST_DATA && rd_r) begin
            spi_sdo <= rd_shift_r[pdc_pkg::DATA_W-1];
            rd_shift_r <= {rd_shift_r[pdc_pkg::DATA_W-2:0], 1'b0};
        end
    end

    // register storage, whole bytes kept including reserved bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fs_r <= pdc_pkg::RST_FIRST_SECOND;
            third_r <= pdc_pkg::RST_THIRD;
            bias_r <= pdc_pkg::RST_BIAS;
            emph_r <= pdc_pkg::RST_EMPH;
            swing_r <= pdc_pkg::RST_SWING;
            trig_r <= pdc_pkg::RST_TRIG;
        end else if (wr_pulse_r) begin
            if (hit(wr_addr_r, pdc_pkg::OFS_FIRST_SECOND)) fs_r <= wr_data_r;
            if (hit(wr_addr_r, pdc_pkg::OFS_THIRD)) third_r <= wr_data_r;
            if (hit(wr_addr_r, pdc_pkg::OFS_BIAS)) bias_r <= wr_data_r;
            if (hit(wr_addr_r, pdc_pkg::OFS_EMPH)) emph_r <= wr_data_r;
            if (hit(wr_addr_r, pdc_pkg::OFS_SWING)) swing_r <= wr_data_r;
            if (hit(wr_addr_r, pdc_pkg::OFS_TRIG)) trig_r <= wr_data_r;
        end
    end

    // pll divider decode, applied at once: pll held in reset by software meanwhile
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_div_ratio <= pdc_pkg::RATIO_5;
            second_div_ratio <= pdc_pkg::RATIO_1;
            third_div_ratio <= pdc_pkg::RST_THIRD[pdc_pkg::THIRD_W-1:0];
            div_code_reserved <= 1'b0;
        end else begin
            case (fs_r[pdc_pkg::FIRST_LSB+:2])
                pdc_pkg::FIRST_CODE_DIV5: first_div_ratio <= pdc_pkg::RATIO_5;
                pdc_pkg::FIRST_CODE_DIV4: first_div_ratio <= pdc_pkg::RATIO_4;
                pdc_pkg::FIRST_CODE_DIV3: first_div_ratio <= pdc_pkg::RATIO_3;
                default: first_div_ratio <= pdc_pkg::RATIO_NONE;
            endcase
            case (fs_r[pdc_pkg::SECOND_LSB+:2])
                pdc_pkg::SECOND_CODE_DIV1: second_div_ratio <= pdc_pkg::RATIO_1;
                pdc_pkg::SECOND_CODE_DIV2: second_div_ratio <= pdc_pkg::RATIO_2;
                pdc_pkg::SECOND_CODE_DIV4: second_div_ratio <= pdc_pkg::RATIO_4;
                default: second_div_ratio <= pdc_pkg::RATIO_NONE;
            endcase
            third_div_ratio <= third_r[pdc_pkg::THIRD_W-1:0];
            div_code_reserved <= (fs_r[pdc_pkg::FIRST_LSB+:2] == 2'h3) ||
                                 (fs_r[pdc_pkg::SECOND_LSB+:2] == 2'h3) ||
                                 (third_r[pdc_pkg::THIRD_W-1:0] == pdc_pkg::THIRD_NONE);
        end
    end

    // bias, emphasis and swing outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscillator_bias_level <= pdc_pkg::RST_BIAS[pdc_pkg::BIAS_W-1:0];
            pll_reference_output_swing <= pdc_pkg::SWING_HIGH;
            trigger_output_swing <= pdc_pkg::SWING_HIGH;
            high_swing_setting <= 1'b1;
        end else begin
            oscillator_bias_level <= bias_r[pdc_pkg::BIAS_W-1:0];
            pll_reference_output_swing <= swing_r[pdc_pkg::SWING_W-1:0];
            trigger_output_swing <= swing_r[pdc_pkg::SWING_W-1:0];
            high_swing_setting <= (swing_r[pdc_pkg::SWING_W-1:0] == pdc_pkg::SWING_HIGH);
        end
    end

    genvar ln;
    generate
        for (ln = 0; ln < pdc_pkg::LANES; ln++) begin : g_lane
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    lane_pre_emphasis[ln*pdc_pkg::EMPH_W+:pdc_pkg::EMPH_W] <= pdc_pkg::RST_EMPH[pdc_pkg::EMPH_W-1:0];
                end else begin
                    lane_pre_emphasis[ln*pdc_pkg::EMPH_W+:pdc_pkg::EMPH_W] <= emph_r[pdc_pkg::EMPH_W-1:0];
                end
            end
        end
    endgenerate

    // trigger output path
    assign trig_en = trig_r[pdc_pkg::TRIG_EN_BIT];
    assign trig_sel = trig_r[pdc_pkg::TRIG_SEL_W-1:0];

    pdc_trig_div u_trig_div (
        .clk(clk),
        .nrst(nrst),
        .enable(trig_en),
        .ui_tick(ser_ui_tick),
        .ser_reinit(ser_reinit),
        .half_count(sel_half(trig_sel)),
        .clk_out(div_clk)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trigger_output <= 1'b0;
            trigger_output_enable <= 1'b0;
            trigger_output_select <= pdc_pkg::TRIG_SEL_UI16;
        end else begin
            trigger_output_enable <= trig_en;
            trigger_output_select <= trig_sel;
            if (!trig_en) begin
                trigger_output <= 1'b0;
            end else if (trig_sel == pdc_pkg::TRIG_SEL_TSTAMP) begin
                trigger_output <= ts_f;
            end else if (trig_sel <= pdc_pkg::TRIG_SEL_UI64) begin
                trigger_output <= div_clk;
            end else begin
                trigger_output <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_FIRST_DIV: assert property (
        (fs_r[1:0] == pdc_pkg::FIRST_CODE_DIV4) |=> (first_div_ratio == pdc_pkg::RATIO_4))
        else $error("first divider ratio wrong");
    AST_FIRST_DIV5: assert property (
        (fs_r[1:0] == pdc_pkg::FIRST_CODE_DIV5) |=> (first_div_ratio == pdc_pkg::RATIO_5))
        else $error("first divider default ratio wrong");
    AST_SECOND_DIV: assert property (
        (fs_r[3:2] == pdc_pkg::SECOND_CODE_DIV4) |=> (second_div_ratio == pdc_pkg::RATIO_4))
        else $error("second divider ratio wrong");
    AST_THIRD_DIV: assert property (
        ##1 (third_div_ratio == $past(third_r[5:0])))
        else $error("third divider does not follow register");
    AST_LANES_EQUAL: assert property (
        ##1 (lane_pre_emphasis == {pdc_pkg::LANES{$past(emph_r[3:0])}}))
        else $error("lane emphasis differs between lanes");
    AST_SWING_BOTH: assert property (
        (pll_reference_output_swing == trigger_output_swing) &&
        (high_swing_setting == (trigger_output_swing == pdc_pkg::SWING_HIGH)))
        else $error("swing outputs disagree");
    AST_TRIG_OFF: assert property (
        !trig_en |=> !trigger_output && !trigger_output_enable)
        else $error("trigger output active while disabled");
    AST_TRIG_TSTAMP: assert property (
        (trig_en && trig_sel == pdc_pkg::TRIG_SEL_TSTAMP) |=> (trigger_output == $past(ts_f)))
        else $error("trigger output not following timestamp");
    AST_TRIG_REINIT: assert property (
        (ser_reinit && trig_en && trig_sel <= pdc_pkg::TRIG_SEL_UI64) ##1
        (trig_en && trig_sel <= pdc_pkg::TRIG_SEL_UI64) |=> !trigger_output)
        else $error("trigger clock survives serializer restart");
    AST_WRITE_THIRD: assert property (
        (wr_pulse_r && wr_addr_r == pdc_pkg::OFS_THIRD) |=> (third_r == $past(wr_data_r)))
        else $error("write to third divider lost");
    AST_BIAS_OUT: assert property (
        $changed(bias_r) |=> (oscillator_bias_level == $past(bias_r[6:0])))
        else $error("bias output stale");
endmodule : pdc_regs
`default_nettype wire

// file: hdl/pdc_pkg.sv
/*
 * constants for the sampling-pll, lane and trigger-output configuration bank:
 * register offsets, reset values, field positions, divider codes and serial frame layout.
 * assumes a 24-bit serial frame: read flag, 15-bit address, 8-bit data, msb first.
 */
package pdc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SYNC_W = 4;
    localparam logic [4:0] CNT_ADDR_DONE = 5'h0f;
    localparam logic [4:0] CNT_FRAME_DONE = 5'h17;
    localparam int RW_BIT = 14;
    localparam logic RW_READ = 1'b1;

    localparam logic [ADDR_W-1:0] OFS_FIRST_SECOND = 15'h003d;
    localparam logic [ADDR_W-1:0] OFS_THIRD = 15'h003e;
    localparam logic [ADDR_W-1:0] OFS_BIAS = 15'h003f;
    localparam logic [ADDR_W-1:0] OFS_EMPH = 15'h0048;
    localparam logic [ADDR_W-1:0] OFS_SWING = 15'h0050;
    localparam logic [ADDR_W-1:0] OFS_TRIG = 15'h0057;

    localparam logic [DATA_W-1:0] RST_FIRST_SECOND = 8'h00;
    localparam logic [DATA_W-1:0] RST_THIRD = 8'h20;
    localparam logic [DATA_W-1:0] RST_BIAS = 8'h4f;
    localparam logic [DATA_W-1:0] RST_EMPH = 8'h00;
    localparam logic [DATA_W-1:0] RST_SWING = 8'h00;
    localparam logic [DATA_W-1:0] RST_TRIG = 8'h00;

    localparam int FIRST_LSB = 0;
    localparam int SECOND_LSB = 2;
    localparam int THIRD_W = 6;
    localparam int BIAS_W = 7;
    localparam int EMPH_W = 4;
    localparam int SWING_W = 2;
    localparam int TRIG_EN_BIT = 7;
    localparam int TRIG_SEL_W = 3;
    localparam int LANES = 8;

    localparam logic [1:0] FIRST_CODE_DIV5 = 2'h0;
    localparam logic [1:0] FIRST_CODE_DIV4 = 2'h1;
    localparam logic [1:0] FIRST_CODE_DIV3 = 2'h2;
    localparam logic [1:0] SECOND_CODE_DIV1 = 2'h0;
    localparam logic [1:0] SECOND_CODE_DIV2 = 2'h1;
    localparam logic [1:0] SECOND_CODE_DIV4 = 2'h2;
    localparam logic [2:0] RATIO_NONE = 3'h0;
    localparam logic [2:0] RATIO_1 = 3'h1;
    localparam logic [2:0] RATIO_2 = 3'h2;
    localparam logic [2:0] RATIO_3 = 3'h3;
    localparam logic [2:0] RATIO_4 = 3'h4;
    localparam logic [2:0] RATIO_5 = 3'h5;
    localparam logic [THIRD_W-1:0] THIRD_NONE = 6'h00;

    localparam logic [SWING_W-1:0] SWING_HIGH = 2'h0;

    localparam logic [2:0] TRIG_SEL_UI16 = 3'h0;
    localparam logic [2:0] TRIG_SEL_UI32 = 3'h1;
    localparam logic [2:0] TRIG_SEL_UI64 = 3'h2;
    localparam logic [2:0] TRIG_SEL_TSTAMP = 3'h3;
    localparam int HALF_W = 6;
    localparam logic [HALF_W-1:0] HALF_UI16 = 6'h08;
    localparam logic [HALF_W-1:0] HALF_UI32 = 6'h10;
    localparam logic [HALF_W-1:0] HALF_UI64 = 6'h20;
    localparam logic [HALF_W-1:0] HALF_NONE = 6'h00;

    typedef enum logic [2:0] {
        PDC_ST_IDLE = 3'b001,
        PDC_ST_ADDR = 3'b010,
        PDC_ST_DATA = 3'b100
    } pdc_spi_state_t;
endpackage : pdc_pkg

// file: hdl/pdc_pin_sync.sv
/*
 * three-flop input synchroniser with agreement filter, one lane per bit.
 * assumes asynchronous inputs; output moves only once stages two and three agree.
 */
`timescale 1ns/10ps
`default_nettype none
module pdc_pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] pin_in,
    output var logic [W-1:0] level_out
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_r <= INIT[g];
                    s2_r <= INIT[g];
                    s3_r <= INIT[g];
                    level_out[g] <= INIT[g];
                end else begin
                    s1_r <= pin_in[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        level_out[g] <= s3_r;
                    end
                end
            end
        end
    endgenerate
endmodule : pdc_pin_sync
`default_nettype wire

// file: hdl/pdc_trig_div.sv
/*
 * divides the serializer unit-interval tick into a square trigger clock.
 * assumes ui_tick and ser_reinit come from logic on clk; half_count of zero stops it.
 */
`timescale 1ns/10ps
`default_nettype none
module pdc_trig_div (
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic ui_tick,
    input wire logic ser_reinit,
    input wire logic [pdc_pkg::HALF_W-1:0] half_count,
    output var logic clk_out
);
    logic [pdc_pkg::HALF_W-1:0] cnt_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= pdc_pkg::HALF_NONE;
            clk_out <= 1'b0;
        end else if (!enable || ser_reinit || half_count == pdc_pkg::HALF_NONE) begin
            // serializer restart breaks the clock
            cnt_r <= pdc_pkg::HALF_NONE;
            clk_out <= 1'b0;
        end else if (ui_tick) begin
            if (cnt_r == half_count - 6'h01) begin
                cnt_r <= pdc_pkg::HALF_NONE;
                clk_out <= ~clk_out;
            end else begin
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end
endmodule : pdc_trig_div
`default_nettype wire

// file: sim/test_pll_divider_output_config_regs.sv
/*
 * self-checking bench for pdc_regs: serial frames, readback, decoded outputs, trigger clock.
 * assumes pdc_pkg and the pdc_regs sources are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module test_pll_divider_output_config_regs;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic sdi = 1'b0;
    logic tick = 1'b0;
    logic reinit = 1'b0;
    logic tstamp = 1'b0;
    wire logic sdo, sdo_oe, rsv, hsw, ten, tout;
    wire logic [2:0] r1, r2, tsel;
    wire logic [5:0] r3;
    wire logic [6:0] bias;
    wire logic [31:0] emph;
    wire logic [1:0] sw_ref, sw_trig;
    int error_cnt = 0;
    int n_checks = 0;
    int n;
    logic [7:0] rd;
    logic [14:0] ofs [6] = '{pdc_pkg::OFS_FIRST_SECOND, pdc_pkg::OFS_THIRD, pdc_pkg::OFS_BIAS,
                             pdc_pkg::OFS_EMPH, pdc_pkg::OFS_SWING, pdc_pkg::OFS_TRIG};
    logic [7:0] rst_v [6] = '{8'h00, 8'h20, 8'h4f, 8'h00, 8'h00, 8'h00};
    logic [7:0] wv [6] = '{8'hf6, 8'hc1, 8'hca, 8'hfb, 8'hfd, 8'h05};
    logic [2:0] fx [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
    logic [2:0] sx [4] = '{3'h1, 3'h2, 3'h4, 3'h0};

    always #50 clk = ~clk;

    pdc_regs u_dut (.clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
        .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .ser_ui_tick(tick), .ser_reinit(reinit),
        .timestamp_input(tstamp), .first_div_ratio(r1), .second_div_ratio(r2),
        .third_div_ratio(r3), .div_code_reserved(rsv), .oscillator_bias_level(bias),
        .lane_pre_emphasis(emph), .pll_reference_output_swing(sw_ref),
        .trigger_output_swing(sw_trig), .high_swing_setting(hsw), .trigger_output_enable(ten),
        .trigger_output_select(tsel), .trigger_output(tout));

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // sclk high for 6 clocks and low for 7 so the pin filter sees every level
    task automatic frame(input logic rdf, input logic [14:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [23:0] f;
        f = {rdf, a, d};
        q = 8'h00;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk) sdi <= f[i];
            repeat (5) @(posedge clk);
            @(negedge clk) if (i < 8) begin
                q[i] = sdo;
                check(sdo_oe, rdf);
            end
            @(posedge clk) sclk <= 1'b1;
            repeat (6) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk) check({sdo_oe, sdo}, 2'b00);
    endtask : frame

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        frame(1'b0, a, d, q);
        @(negedge clk);
    endtask : wr

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        frame(1'b1, a, 8'h00, rd);
        check(rd, e);
    endtask : rd_chk

    // bounded wait for a trigger level; n ends as the number of cycles waited
    task automatic wait_tout(input logic v);
        n = 0;
        while (tout !== v) begin
            if (n == 200) begin
                error_cnt++;
                tally_and_finish();
            end
            @(negedge clk) n++;
        end
    endtask : wait_tout

    // full high phase only: the clock may already be high when this starts
    task automatic half_period(input int e);
        wait_tout(1'b0);
        wait_tout(1'b1);
        check({ten, tout}, 2'b11);
        wait_tout(1'b0);
        check(n, e);
    endtask : half_period

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check({r1, r2, r3, rsv, bias}, {3'h5, 3'h1, 6'h20, 1'b0, 7'h4f});
        check(emph, 32'h0);
        check({sw_ref, sw_trig, hsw, ten, tout}, {4'h0, 3'b100});
        repeat (6) @(posedge clk);
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], rst_v[i]);
        for (int c = 0; c < 4; c++) begin
            wr(ofs[0], {4'h0, c[1:0], c[1:0]}); // pll taken as held in reset meanwhile
            check({r1, r2}, {fx[c], sx[c]});
            check(rsv, c == 3);
        end
        wr(ofs[0], 8'h00);
        wr(ofs[1], 8'h3f);
        check({r3, rsv}, {6'h3f, 1'b0});
        wr(ofs[1], 8'h00);
        check(rsv, 1'b1);
        for (int i = 0; i < 6; i++) wr(ofs[i], wv[i]); // bias field written as 0x4a
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], wv[i]);
        check({r1, r2, r3, bias}, {3'h3, 3'h2, 6'h01, 7'h4a});
        check(emph, {8{4'hb}});
        check({sw_ref, sw_trig, hsw}, {4'h5, 1'b0});
        wr(15'h0049, 8'h5a);
        rd_chk(15'h0049, 8'h00);
        tick <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            wr(ofs[5], {5'h0, s[2:0]}); // select changed only while disabled
            check({ten, tout}, 2'b00);
            wr(ofs[5], {5'h10, s[2:0]});
            check({ten, tsel}, {1'b1, s[2:0]});
            half_period(8 << s);
        end
        wait_tout(1'b1);
        @(posedge clk) reinit <= 1'b1;
        @(posedge clk) reinit <= 1'b0;
        repeat (2) @(negedge clk);
        check(tout, 1'b0);
        wr(ofs[5], 8'h03);
        wr(ofs[5], 8'h83);
        @(posedge clk) tstamp <= 1'b1;
        repeat (8) @(negedge clk);
        check(tout, 1'b1);
        @(posedge clk) tstamp <= 1'b0;
        repeat (8) @(negedge clk);
        check(tout, 1'b0);
        wr(ofs[5], 8'h00);
        wr(ofs[5], 8'h85);
        check(tout, 1'b0);
        wr(ofs[5], 8'h05);
        check({ten, tout}, 2'b00);
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule : test_pll_divider_output_config_regs
`default_nettype wire
